// ---- mlotw_mem_model.sv ----
// Descriptor memory model on the walker's fetch port.
// Assumes the bench preloads words, indexed by address bits 13:2.
`timescale 1ns/1ps
module mlotw_mem_model (
    // Clock, reset and answer delay
    input  wire logic        sys_clk_in,
    input  wire logic        reset_n_in,
    input  wire logic [3:0]  wait_in,
    // Fetch port
    input  wire logic        mem_req_in,
    input  wire logic [31:0] mem_addr_in,
    output logic             mem_ack_out,
    output logic [31:0]      mem_rdata_out
);
    logic [31:0] words [0:4095];
    logic [3:0]  cnt_ff;
    // ==========================================
    // One word a request; data scrambled when idle
    always_ff @(posedge sys_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            cnt_ff <= 4'h0;
            mem_ack_out <= 1'b0;
            mem_rdata_out <= 32'h0;
        end
        else if (mem_req_in && !mem_ack_out && cnt_ff == wait_in)
        begin
            cnt_ff <= 4'h0;
            mem_ack_out <= 1'b1;
            mem_rdata_out <= words[mem_addr_in[13:2]];
        end
        else
        begin
            cnt_ff <= (mem_req_in && !mem_ack_out) ? cnt_ff + 4'h1 : 4'h0;
            mem_ack_out <= 1'b0;
            mem_rdata_out <= ~mem_rdata_out;
        end
    end
endmodule

// ---- mlotw_pkg.sv ----
// Level one table walker: shared constants, types and states.
// Assumes a single processor clock domain and a coprocessor-style register port.
package mlotw_pkg;

    // ==========================================================
    // Register numbers on the coprocessor port
    localparam logic [3:0] CP_REG_CONTROL   = 4'h1;
    localparam logic [3:0] CP_REG_TTB       = 4'h2;
    localparam logic [3:0] CP_REG_DOMAIN    = 4'h3;
    localparam logic [3:0] CP_REG_FSTATUS   = 4'h5;
    localparam logic [3:0] CP_REG_FADDR     = 4'h6;
    localparam logic [3:0] CP_REG_TLB_OP    = 4'h8;
    localparam logic [3:0] CP_REG_PROC_ID   = 4'hd;

    // ==========================================================
    // Field positions and reset values
    localparam int CTRL_MMU_EN_BIT  = 0;
    localparam int CTRL_ALIGN_BIT   = 1;
    localparam int CTRL_SYS_BIT     = 8;
    localparam int CTRL_ROM_BIT     = 9;
    localparam int TTB_LSB          = 14;
    localparam int SECTION_LSB      = 20;
    localparam int COARSE_LSB       = 10;
    localparam int FINE_LSB         = 12;
    localparam int PID_LSB          = 25;
    localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
    localparam logic [31:0] DOMAIN_RESET = 32'h0000_0000;
    localparam logic [7:0]  FSR_RESET    = 8'h00;

    // ==========================================================
    // Descriptor type codes, TLB operations and fault codes
    localparam logic [1:0] DESC_INVALID = 2'h0;
    localparam logic [1:0] DESC_COARSE  = 2'h1;
    localparam logic [1:0] DESC_SECTION = 2'h2;
    localparam logic [1:0] DESC_FINE    = 2'h3;
    localparam logic [2:0] TLB_OP_ALL   = 3'h0;
    localparam logic [2:0] TLB_OP_ENTRY = 3'h1;
    localparam logic [3:0] FAULT_SECT_XLATE = 4'h5;
    localparam logic [3:0] FAULT_SECT_DOMAIN = 4'h9;
    localparam logic [3:0] FAULT_SECT_PERM  = 4'hd;
    localparam logic [1:0] DOM_NO_ACCESS = 2'h0;
    localparam logic [1:0] DOM_CLIENT    = 2'h1;
    localparam logic [1:0] DOM_MANAGER   = 2'h3;

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic        valid;
        logic [11:0] tag;
        logic [11:0] pa_base;
        logic [1:0]  access_perm;
        logic [3:0]  domain;
        logic        cachable;
        logic        bufferable;
    } mlotw_tlb_entry_type;

    typedef struct packed {
        logic [31:0] modified_virtual_address;
        logic        write;
        logic        priv;
    } mlotw_req_type;

    typedef struct packed {
        logic [31:0] phys_addr;
        logic        abort;
        logic        cachable;
        logic        bufferable;
    } mlotw_resp_type;

    typedef struct packed {
        logic [31:0] table_base;
        logic        fine;
        logic [3:0]  domain;
        logic [31:0] modified_virtual_address;
    } mlotw_l2_type;

    typedef enum logic [1:0] {ST_IDLE, ST_LOOK, ST_WALK} mlotw_state_type;

endpackage

// ---- mlotw_walker.sv ----
// Level one translation table walker with TLB, permission check and MMU registers.
// Assumes memory and the level two stage run on sys_clk_in; no synchronisers needed.
`timescale 1ns/1ps

module mlotw_walker #(
    parameter int TLB_ENTRIES = 64
) (
    // Clock and reset
    input  wire logic                 sys_clk_in,
    input  wire logic                 reset_n_in,
    // Core translation request
    input  wire logic                 req_valid_in,
    input  wire mlotw_pkg::mlotw_req_type req_in,
    output logic                      req_ready_out,
    // Translation answer
    output logic                      resp_valid_out,
    output mlotw_pkg::mlotw_resp_type resp_out,
    // Descriptor fetch from memory
    output logic                      mem_req_out,
    output logic [31:0]               mem_addr_out,
    input  wire logic                 mem_ack_in,
    input  wire logic [31:0]          mem_rdata_in,
    // Level two stage hand-off
    output logic                      l2_start_out,
    output mlotw_pkg::mlotw_l2_type   l2_out,
    // System control coprocessor register port
    input  wire logic                 cp_write_in,
    input  wire logic                 cp_read_in,
    input  wire logic [3:0]           cp_reg_in,
    input  wire logic [2:0]           cp_op_in,
    input  wire logic [31:0]          cp_wdata_in,
    output logic                      cp_rvalid_out,
    output logic [31:0]               cp_rdata_out
);
    import mlotw_pkg::*;

    localparam int IDX_W = $clog2(TLB_ENTRIES);

    mlotw_state_type     state_ff;
    mlotw_req_type       req_q_ff;
    mlotw_tlb_entry_type tlb_ff [TLB_ENTRIES];
    logic [IDX_W-1:0]    victim_ff;
    logic [31:0]         ctrl_ff;
    logic [31:14]        ttb_ff;
    logic [31:0]         domain_ff;
    logic [7:0]          fsr_ff;
    logic [31:0]         far_ff;
    logic [31:25]        pid_ff;
    logic [31:0]         mem_addr_ff;
    logic                resp_valid_ff;
    mlotw_resp_type      resp_ff;
    logic                l2_start_ff;
    mlotw_l2_type        l2_ff;
    logic                cp_rvalid_ff;
    logic [31:0]         cp_rdata_ff;

    // ==========================================================
    // Address modification, TLB lookup and permission check
    logic                accept;
    logic [31:0]         nxt_mva;
    logic                hit;
    logic [IDX_W-1:0]    hit_idx;
    mlotw_tlb_entry_type hit_entry;
    logic [1:0]          dom_ctl;
    logic                perm_ok;
    logic                walk_done;
    logic [1:0]          desc_type;
    logic                fault_now;

    assign accept    = req_valid_in && (state_ff == ST_IDLE);
    assign req_ready_out = (state_ff == ST_IDLE);
    assign walk_done = (state_ff == ST_WALK) && mem_ack_in;
    assign desc_type = mem_rdata_in[1:0];

    always_comb
    begin
        nxt_mva = req_in.modified_virtual_address;
        if (req_in.modified_virtual_address[31:PID_LSB] == '0)
        begin
            nxt_mva = {pid_ff, req_in.modified_virtual_address[PID_LSB-1:0]};
        end
    end

    always_comb
    begin
        hit       = 1'b0;
        hit_idx   = '0;
        for (int i = 0; i < TLB_ENTRIES; i++)
        begin
            if (!hit && tlb_ff[i].valid && tlb_ff[i].tag == req_q_ff.modified_virtual_address[31:SECTION_LSB])
            begin
                hit     = 1'b1;
                hit_idx = IDX_W'(i);
            end
        end
        hit_entry = tlb_ff[hit_idx];
    end

    assign dom_ctl = domain_ff[{hit_entry.domain, 1'b0} +: 2];

    always_comb
    begin
        // Section permission field against privilege and S/R bits
        perm_ok = 1'b0;
        case (hit_entry.access_perm)
            2'h0:
            begin
                if (!req_q_ff.write)
                begin
                    perm_ok = (ctrl_ff[CTRL_SYS_BIT] && !ctrl_ff[CTRL_ROM_BIT] && req_q_ff.priv)
                           || (!ctrl_ff[CTRL_SYS_BIT] && ctrl_ff[CTRL_ROM_BIT]);
                end
            end
            2'h1:    perm_ok = req_q_ff.priv;
            2'h2:    perm_ok = req_q_ff.priv || !req_q_ff.write;
            2'h3:    perm_ok = 1'b1;
            default: perm_ok = 1'b0;
        endcase
    end

    assign fault_now = (state_ff == ST_LOOK) && ctrl_ff[CTRL_MMU_EN_BIT] && hit
                     && !((dom_ctl == DOM_MANAGER) || (dom_ctl == DOM_CLIENT && perm_ok));

    // ==========================================================
    // Walk sequencing
    always_ff @(posedge sys_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            state_ff <= ST_IDLE;
        end
        else
        begin
            case (state_ff)
                ST_IDLE:
                begin
                    if (accept)
                    begin
                        state_ff <= ST_LOOK;
                    end
                end
                ST_LOOK:
                begin
                    if (ctrl_ff[CTRL_MMU_EN_BIT] && !hit)
                    begin
                        state_ff <= ST_WALK;
                    end
                    else
                    begin
                        state_ff <= ST_IDLE;
                    end
                end
                ST_WALK:
                begin
                    if (mem_ack_in)
                    begin
                        // Sections finish via a fresh lookup; pages leave for level two
                        state_ff <= (desc_type == DESC_SECTION) ? ST_LOOK : ST_IDLE;
                    end
                end
                default: state_ff <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            req_q_ff <= '0;
        end
        else if (accept)
        begin
            req_q_ff <= '{modified_virtual_address: nxt_mva, write: req_in.write, priv: req_in.priv};
        end
    end

    always_ff @(posedge sys_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            mem_addr_ff <= '0;
        end
        else if (state_ff == ST_LOOK)
        begin
            // Word-aligned 32-bit byte address into a 4096-entry table
            mem_addr_ff <= {ttb_ff, req_q_ff.modified_virtual_address[31:SECTION_LSB], 2'b00};
        end
    end

    assign mem_req_out  = (state_ff == ST_WALK);
    assign mem_addr_out = mem_addr_ff;

    // ==========================================================
    // TLB fill, round-robin victim and invalidation
    always_ff @(posedge sys_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            for (int i = 0; i < TLB_ENTRIES; i++)
            begin
                tlb_ff[i] <= '0;
            end
        end
        else
        begin
            if (cp_write_in && cp_reg_in == CP_REG_TLB_OP)
            begin
                for (int i = 0; i < TLB_ENTRIES; i++)
                begin
                    if (cp_op_in == TLB_OP_ALL
                        || (cp_op_in == TLB_OP_ENTRY
                            && tlb_ff[i].tag == cp_wdata_in[31:SECTION_LSB]))
                    begin
                        tlb_ff[i].valid <= 1'b0;
                    end
                end
            end
            if (walk_done && desc_type == DESC_SECTION)
            begin
                tlb_ff[victim_ff] <= '{valid:       1'b1,
                                       tag:         req_q_ff.modified_virtual_address[31:SECTION_LSB],
                                       pa_base:     mem_rdata_in[31:SECTION_LSB],
                                       access_perm: mem_rdata_in[11:10],
                                       domain:      mem_rdata_in[8:5],
                                       cachable:    mem_rdata_in[3],
                                       bufferable:  mem_rdata_in[2]};
            end
        end
    end

    always_ff @(posedge sys_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            victim_ff <= '0;
        end
        else if (walk_done && desc_type == DESC_SECTION)
        begin
            victim_ff <= victim_ff + 1'b1;
        end
    end

    // ==========================================================
    // Answer to the core and level two hand-off
    always_ff @(posedge sys_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            resp_valid_ff <= 1'b0;
            resp_ff       <= '0;
        end
        else
        begin
            resp_valid_ff <= 1'b0;
            if (state_ff == ST_LOOK && !ctrl_ff[CTRL_MMU_EN_BIT])
            begin
                resp_valid_ff <= 1'b1;
                resp_ff       <= '{phys_addr: req_q_ff.modified_virtual_address, abort: 1'b0,
                                   cachable: 1'b0, bufferable: 1'b0};
            end
            else if (state_ff == ST_LOOK && hit)
            begin
                resp_valid_ff <= 1'b1;
                // Write-through: bufferable only marks the write buffer path
                resp_ff <= '{phys_addr: {hit_entry.pa_base, req_q_ff.modified_virtual_address[SECTION_LSB-1:0]},
                             abort:      fault_now,
                             cachable:   hit_entry.cachable,
                             bufferable: hit_entry.bufferable};
            end
            else if (walk_done && desc_type == DESC_INVALID)
            begin
                resp_valid_ff <= 1'b1;
                resp_ff       <= '{phys_addr: '0, abort: 1'b1,
                                   cachable: 1'b0, bufferable: 1'b0};
            end
        end
    end

    always_ff @(posedge sys_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            l2_start_ff <= 1'b0;
            l2_ff       <= '0;
        end
        else
        begin
            l2_start_ff <= 1'b0;
            if (walk_done && (desc_type == DESC_COARSE || desc_type == DESC_FINE))
            begin
                l2_start_ff <= 1'b1;
                l2_ff.fine   <= (desc_type == DESC_FINE);
                l2_ff.domain <= mem_rdata_in[8:5];
                l2_ff.modified_virtual_address    <= req_q_ff.modified_virtual_address;
                if (desc_type == DESC_FINE)
                begin
                    l2_ff.table_base <= {mem_rdata_in[31:FINE_LSB], 12'h000};
                end
                else
                begin
                    l2_ff.table_base <= {mem_rdata_in[31:COARSE_LSB], 10'h000};
                end
            end
        end
    end

    assign resp_valid_out = resp_valid_ff;
    assign resp_out       = resp_ff;
    assign l2_start_out   = l2_start_ff;
    assign l2_out         = l2_ff;

    // ==========================================================
    // Coprocessor registers
    always_ff @(posedge sys_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            ctrl_ff   <= CTRL_RESET;
            ttb_ff    <= '0;
            domain_ff <= DOMAIN_RESET;
            pid_ff    <= '0;
        end
        else if (cp_write_in)
        begin
            case (cp_reg_in)
                CP_REG_CONTROL:
                begin
                    ctrl_ff <= cp_wdata_in & ((32'h1 << CTRL_MMU_EN_BIT) | (32'h1 << CTRL_ALIGN_BIT)
                               | (32'h1 << CTRL_SYS_BIT) | (32'h1 << CTRL_ROM_BIT));
                end
                CP_REG_TTB:      ttb_ff    <= cp_wdata_in[31:TTB_LSB];
                CP_REG_DOMAIN:   domain_ff <= cp_wdata_in;
                CP_REG_PROC_ID:  pid_ff    <= cp_wdata_in[31:PID_LSB];
                default:         ttb_ff    <= ttb_ff;
            endcase
        end
    end

    // Hardware abort update wins over a software write in the same cycle
    always_ff @(posedge sys_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            fsr_ff <= FSR_RESET;
            far_ff <= '0;
        end
        else if (walk_done && desc_type == DESC_INVALID)
        begin
            fsr_ff <= {mem_rdata_in[8:5], FAULT_SECT_XLATE};
            far_ff <= req_q_ff.modified_virtual_address;
        end
        else if (fault_now)
        begin
            fsr_ff <= {hit_entry.domain,
                       (dom_ctl == DOM_CLIENT) ? FAULT_SECT_PERM : FAULT_SECT_DOMAIN};
            far_ff <= req_q_ff.modified_virtual_address;
        end
        else if (cp_write_in && cp_reg_in == CP_REG_FSTATUS)
        begin
            fsr_ff <= cp_wdata_in[7:0];
        end
        else if (cp_write_in && cp_reg_in == CP_REG_FADDR)
        begin
            far_ff <= cp_wdata_in;
        end
    end

    always_ff @(posedge sys_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            cp_rvalid_ff <= 1'b0;
            cp_rdata_ff  <= '0;
        end
        else
        begin
            cp_rvalid_ff <= cp_read_in;
            case (cp_reg_in)
                CP_REG_CONTROL:  cp_rdata_ff <= ctrl_ff;
                CP_REG_TTB:      cp_rdata_ff <= {ttb_ff, 14'h0000};
                CP_REG_DOMAIN:   cp_rdata_ff <= domain_ff;
                CP_REG_FSTATUS:  cp_rdata_ff <= {24'h000000, fsr_ff};
                CP_REG_FADDR:    cp_rdata_ff <= far_ff;
                CP_REG_PROC_ID:  cp_rdata_ff <= {pid_ff, 25'h0000000};
                default:         cp_rdata_ff <= 32'h0000_0000;
            endcase
        end
    end

    assign cp_rvalid_out = cp_rvalid_ff;
    assign cp_rdata_out  = cp_rdata_ff;

    // ==========================================================
    // Checks
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!reset_n_in);

    sequence s_miss;
        state_ff == ST_LOOK && ctrl_ff[CTRL_MMU_EN_BIT] && !hit;
    endsequence
    sequence s_section_ack;
        walk_done && desc_type == DESC_SECTION;
    endsequence

    chk_walk_on_miss: assert property (
        s_miss |=> mem_req_out && mem_addr_out[31:14] == ttb_ff)
        else $error("miss did not start a level one fetch");
    chk_no_walk_hit: assert property (
        state_ff == ST_LOOK && hit |=> !mem_req_out)
        else $error("walk started on a hit");
    chk_l1_address: assert property (
        mem_req_out |-> mem_addr_out == {ttb_ff, req_q_ff.modified_virtual_address[31:20], 2'b00})
        else $error("level one address wrong");
    chk_section_fill: assert property (
        s_section_ack ##1 (state_ff == ST_LOOK) |-> hit ##1 resp_valid_out)
        else $error("section fill did not hit");
    chk_section_pa: assert property (
        s_section_ack |=> ##1 resp_out.phys_addr[31:20] == $past(mem_rdata_in[31:20], 2))
        else $error("section physical base wrong");
    chk_invalid_fault: assert property (
        walk_done && desc_type == DESC_INVALID
        |=> resp_valid_out && resp_out.abort && fsr_ff[3:0] == FAULT_SECT_XLATE
            && far_ff == req_q_ff.modified_virtual_address)
        else $error("invalid descriptor not faulted");
    chk_coarse_handoff: assert property (
        walk_done && desc_type == DESC_COARSE
        |=> l2_start_out && !l2_out.fine && l2_out.table_base[31:10] == $past(mem_rdata_in[31:10]))
        else $error("coarse hand-off wrong");
    chk_fine_handoff: assert property (
        walk_done && desc_type == DESC_FINE
        |=> l2_start_out && l2_out.fine && l2_out.table_base[31:12] == $past(mem_rdata_in[31:12])
            && l2_out.domain == $past(mem_rdata_in[8:5]))
        else $error("fine hand-off wrong");
    chk_round_robin: assert property (
        s_section_ack |=> victim_ff == IDX_W'($past(victim_ff) + 1'b1))
        else $error("victim pointer did not step");
    chk_pass_through: assert property (
        state_ff == ST_LOOK && !ctrl_ff[CTRL_MMU_EN_BIT]
        |=> resp_valid_out && resp_out.phys_addr == req_q_ff.modified_virtual_address && !resp_out.cachable
            && !resp_out.bufferable && state_ff == ST_IDLE)
        else $error("disabled MMU did not pass through");
    chk_ttb_read: assert property (
        cp_read_in && cp_reg_in == CP_REG_TTB |=> cp_rvalid_out && cp_rdata_out[13:0] == 14'h0)
        else $error("table base low bits not zero");
    chk_abort_logged: assert property (
        fault_now |=> resp_out.abort && far_ff == $past(req_q_ff.modified_virtual_address))
        else $error("abort did not log fault address");

endmodule

// ---- tb_mmu_level_one_table_walk.sv ----
// Self-checking bench for the level one table walker.
// Assumes the memory model on the fetch port and no level two stage.
`timescale 1ns/1ps
module tb_mmu_level_one_table_walk;
    import mlotw_pkg::*;
    typedef struct {int k; logic [31:0] va, d, e; logic [4:0] fl;} mlotw_row_type;
    logic sys_clk_in = 0, reset_n_in = 0, req_valid_in = 0, cp_write_in = 0, cp_read_in = 0;
    logic req_ready_out, resp_valid_out, mem_req_out, mem_ack_in, l2_start_out, cp_rvalid_out, f;
    logic [3:0] cp_reg_in = 0, wait_in = 0;
    logic [2:0] cp_op_in = 0;
    logic [31:0] cp_wdata_in = 0, cp_rdata_out, mem_addr_out, mem_rdata_in, rd;
    mlotw_req_type req_in = '0;
    mlotw_resp_type resp_out;
    mlotw_l2_type l2_out;
    int err_total = 0, checked = 0;
    logic [6:0] pid = 0;
    mlotw_row_type rows [6] = '{
        '{0, 32'h4012_3456, 32'h8760_0c1e, 32'h8762_3456, 5'h03},
        '{0, 32'h7ff0_0010, 32'h0010_0c12, 32'h0010_0010, 5'h00},
        '{1, 32'h0050_0000, 32'h1234_5431, 32'h1234_5400, 5'h01},
        '{1, 32'h0060_0000, 32'h1234_5053, 32'h1234_5000, 5'h12},
        '{2, 32'h0070_0000, 32'h0000_0000, 32'h0000_0005, 5'h04},
        '{2, 32'h0090_0000, 32'h0090_0c52, 32'h0000_0029, 5'h04}};
    mlotw_walker dut (.sys_clk_in, .reset_n_in, .req_valid_in, .req_in, .req_ready_out,
        .resp_valid_out, .resp_out, .mem_req_out, .mem_addr_out, .mem_ack_in, .mem_rdata_in,
        .l2_start_out, .l2_out, .cp_write_in, .cp_read_in, .cp_reg_in, .cp_op_in,
        .cp_wdata_in, .cp_rvalid_out, .cp_rdata_out);
    mlotw_mem_model mem (.sys_clk_in, .reset_n_in, .wait_in, .mem_req_in(mem_req_out),
        .mem_addr_in(mem_addr_out), .mem_ack_out(mem_ack_in), .mem_rdata_out(mem_rdata_in));
    always #5 sys_clk_in = ~sys_clk_in;
    // ==========================================
    // Shared tasks
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic cp(input logic wr, input logic [3:0] r, input logic [2:0] op,
                      input logic [31:0] w, output logic [31:0] d);
        @(posedge sys_clk_in);
        {cp_write_in, cp_read_in, cp_reg_in, cp_op_in, cp_wdata_in} <= {wr, !wr, r, op, w};
        @(posedge sys_clk_in);
        {cp_write_in, cp_read_in} <= 2'b00;
        #1;
        d = cp_rdata_out;
        if (!wr) chk("rvalid", cp_rvalid_out, 1);
    endtask
    task automatic xlate(input logic [31:0] va, input logic [3:0] w, output logic fe);
        logic [31:0] modified_virtual_address;
        modified_virtual_address = (va[31:25] == 7'h00) ? {pid, va[24:0]} : va;
        fe = 0;
        @(posedge sys_clk_in);
        req_valid_in <= 1;
        req_in <= '{modified_virtual_address: va, write: 1'b0, priv: 1'b1};
        wait_in <= w;
        @(posedge sys_clk_in);
        req_valid_in <= 0;
        repeat (100)
        begin
            #1;
            if (mem_req_out && !fe)
                chk("daddr", mem_addr_out, {18'h00048, modified_virtual_address[31:20], 2'b00});
            fe = fe | mem_req_out;
            if (resp_valid_out || l2_start_out) break;
            @(posedge sys_clk_in);
        end
        chk("answer", resp_valid_out || l2_start_out, 1);
    endtask
    task automatic end_of_test();
        $display("checked %0d err_total %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // ==========================================
    // Watchdog and main sequence
    initial
    begin
        repeat (5000) @(posedge sys_clk_in);
        err_total++;
        end_of_test();
    end
    initial
    begin
        foreach (rows[i]) mem.words[rows[i].va[31:20]] = rows[i].d;
        repeat (12) @(posedge sys_clk_in);
        reset_n_in <= 1;
        xlate(32'h4012_3456, 4'h0, f);
        chk("off_pa", resp_out.phys_addr, 32'h4012_3456);
        chk("off_cbf", {resp_out.cachable, resp_out.bufferable, f}, 0);
        cp(0, CP_REG_TTB, 0, 0, rd);
        chk("ttb_rst", rd, 0);
        cp(1, CP_REG_TTB, 0, 32'h0012_3fff, rd);
        cp(0, CP_REG_TTB, 0, 0, rd);
        chk("ttb_rd", rd, 32'h0012_0000);
        cp(0, 4'h4, 0, 0, rd);
        chk("unmapped", rd, 0);
        cp(1, CP_REG_DOMAIN, 0, 32'h7, rd);
        cp(1, CP_REG_CONTROL, 0, 32'h1, rd);
        $display("test reset_regs done");
        foreach (rows[i])
        begin
            xlate(rows[i].va, i[0] ? 4'h5 : 4'h0, f);
            chk("fetch", f, 1);
            chk("l2go", l2_start_out, rows[i].k == 1);
            if (rows[i].k == 1)
            begin
                chk("l2base", l2_out.table_base, rows[i].e);
                chk("l2fd", {l2_out.fine, l2_out.domain}, rows[i].fl);
                chk("l2va", l2_out.modified_virtual_address, rows[i].va);
            end
            else if (rows[i].k == 0)
            begin
                chk("pa", resp_out.phys_addr, rows[i].e);
                chk("acb", {resp_out.abort, resp_out.cachable, resp_out.bufferable}, rows[i].fl);
            end
            else
            begin
                chk("abort", resp_out.abort, 1);
                cp(0, CP_REG_FSTATUS, 0, 0, rd);
                chk("fsr", rd, rows[i].e);
                cp(0, CP_REG_FADDR, 0, 0, rd);
                chk("far", rd, rows[i].va);
            end
        end
        $display("test walks done");
        xlate(32'h4012_3456, 4'h0, f);
        chk("hit_f", f, 0);
        chk("hit_pa", resp_out.phys_addr, 32'h8762_3456);
        cp(1, CP_REG_TLB_OP, TLB_OP_ALL, 0, rd);
        xlate(32'h4012_3456, 4'h3, f);
        chk("refetch", f, 1);
        $display("test tlb_hit_flush done");
        cp(1, CP_REG_PROC_ID, 0, 32'h0200_0000, rd);
        mem.words[12'h021] = 32'habc0_0032;
        pid = 7'h01;
        xlate(32'h0010_0000, 4'h1, f);
        chk("pid_pa", resp_out.phys_addr, 32'habc0_0000);
        chk("perm", resp_out.abort, 1);
        cp(0, CP_REG_FSTATUS, 0, 0, rd);
        chk("fsr_perm", rd, 32'h0000_001d);
        cp(0, CP_REG_FADDR, 0, 0, rd);
        chk("far_pid", rd, 32'h0210_0000);
        cp(1, CP_REG_TLB_OP, TLB_OP_ENTRY, 32'h0210_0000, rd);
        xlate(32'h0010_0000, 4'h0, f);
        chk("inv_one", f, 1);
        xlate(32'h4012_3456, 4'h0, f);
        chk("kept", f, 0);
        $display("test pid_perm done");
        end_of_test();
    end
endmodule
